// ==== verilog/adc_port_regs.svh ====
// Timing counts, widths and reset values of the converter serial port
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

// Word framing
`define WORD_BITS 5'h10
`define LAST_BIT 5'h0f
`define WORD_RST 16'h0000
`define CNT_RST 5'h00

// Frame sync lead after convert start, in master clock periods
`define SYNC_LEAD_LAST 5'h02
// Conversion length in the slave modes, in master clock periods
`define CONV_LAST 5'h12

// Power-up calibration: time in ms at a master clock in kHz
`define CAL_TIME_MS 42
`define MCLK_KHZ 6000
`define CAL_MCLKS (`CAL_TIME_MS * `MCLK_KHZ)

// Pin sampler reset: frame sync and convert start idle high
`define PINS_RST 8'h28

// Write word buffer
`define FIFO_WIDTH 16
`define FIFO_DEPTH 16

`endif

// ==== verilog/adc_port_pkg.sv ====
// Types shared by the converter serial port
`default_nettype none

package adc_port_pkg;

  typedef enum logic [1:0] {
    MODE_THREE_WIRE = 2'b00,
    MODE_EDGE_SLAVE = 2'b01,
    MODE_GATED = 2'b10,
    MODE_FREE = 2'b11
  } port_mode_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARM = 3'b001,
    ST_LEAD = 3'b010,
    ST_FRAME = 3'b011,
    ST_CONV = 3'b100
  } conv_state_type;

  typedef struct packed {
    logic mclk;
    logic sclk;
    logic sync;
    logic din;
    logic convert_start_n_n;
    logic pol;
    logic [1:0] msel;
  } pins_type;

endpackage : adc_port_pkg

`default_nettype wire

// ==== verilog/adc_serial_port.sv ====
// Serial port of a sampling converter with its write word buffer
//
// Function
// [R1] Edge slave: frame starts at sync fall, 16 bits
// [R2] Host sync high pulse may be brief
// [R3] Output floats while sync high, launches on falls
// [R4] Input sampled on bit clock rising edges
// [R5] Polarity input swaps capture and launch edges
// [R6] Sync high then low restarts bit framing
// [R7] Master modes drive clock and sync, stopped in calibration
// [R8] Free mode passes master clock, gated mode gates
// [R9] Current result shifted out during its conversion
// [R10] Convert start fall begins conversion, raises busy
// [R11] Sync falls three master clocks after start rise
// [R12] After 16 bits sync high, busy low
// [R13] Host waits acquisition time before next start
// [R14] Sync falls only after a bit clock rise
// [R15] Master launches at sync fall then on rises
// [R16] Sync rises after sixteenth rise, no extra bit
// [R17] Software start bit starts conversion and frame; in slave modes it starts only the conversion
// [R18] Software start in master modes locks out writes; two-wire writes ignore the lockout
// [R19] Power-up calibration counts master clock periods
// [R20] Two-wire mode only by select bit
// [R21] All-zero write words change nothing
// [R22] Host avoids software start in master modes
// [R23] Mode pins select interface mode
// [R24] Every transfer is one 16-bit word
// [R25] Bit counter saturates at 16 until next frame
`include "adc_port_regs.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module word_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : bad_shape
    $error("word_fifo: depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  // The output stage is a register so the draining port sees flip-flops
  wire push = in_valid && in_ready;
  wire stage_free = !out_valid || out_ready;
  wire pop = stage_free && (count != '0);

  // The output stage counts as one of the DEPTH words
  assign in_ready = ((AW+1)'(out_valid) + count) != (AW+1)'(DEPTH);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
      end
      if (stage_free) begin
        out_valid <= pop;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : word_fifo

////////////////////////////////////////////////////////////////////////////////

module adc_serial_port import adc_port_pkg::*; #(
  parameter int unsigned CAL_MCLKS = `CAL_MCLKS,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Master clock, start pin and strapping pins
  input wire logic master_clock_input,
  input wire logic convert_start_n,
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  input wire logic polarity,
  // Control bits
  input wire logic sw_convert_start,
  input wire logic two_wire_select,
  // Serial link
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  input wire logic din_in,
  output logic din_out,
  output logic din_oe,
  output logic dout,
  output logic dout_oe,
  // Converter core
  input wire logic [15:0] result_word,
  output logic busy,
  output logic calibrating,
  output logic locked_out,
  // Received write words
  output logic wr_valid,
  output logic [15:0] wr_data,
  input wire logic wr_ready
);
  localparam int CAL_W = $clog2(CAL_MCLKS + 1);

  if (CAL_MCLKS < 1) begin : bad_cal
    $error("adc_serial_port: calibration count must be at least 1");
  end

  function automatic logic edge_up(input logic cur, input logic prev);
    return cur && !prev;
  endfunction : edge_up

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling: stage one feeds only stage two

  pins_type pin_raw;
  pins_type pin_s1;
  pins_type pin_s2;
  pins_type pin_d;

  assign pin_raw = {master_clock_input, sclk_in, sync_in, din_in,
                    convert_start_n, polarity, mode_select_hi, mode_select_lo};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= `PINS_RST;
      pin_s2 <= `PINS_RST;
      pin_d <= `PINS_RST;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoding

  wire port_mode_type mode = port_mode_type'(pin_s2.msel); // see [R23]
  wire is_master = mode[1];
  wire two_wire = (mode == MODE_THREE_WIRE) && two_wire_select; // see [R20]
  wire pol = pin_s2.pol;

  wire mclk_rise = edge_up(pin_s2.mclk, pin_d.mclk);
  wire mclk_fall = edge_up(pin_d.mclk, pin_s2.mclk);
  wire sclk_rise = edge_up(pin_s2.sclk, pin_d.sclk);
  wire sclk_fall = edge_up(pin_d.sclk, pin_s2.sclk);
  wire sync_fall = edge_up(pin_d.sync, pin_s2.sync);
  wire convert_start_n_fall = edge_up(pin_d.convert_start_n_n, pin_s2.convert_start_n_n);
  wire convert_start_n_rise = edge_up(pin_s2.convert_start_n_n, pin_d.convert_start_n_n);

  // Master mode bit clock follows the master clock, so its edges are ours
  wire m_cap = pol ? mclk_fall : mclk_rise; // see [R15] see [R5]
  wire s_cap = pol ? sclk_fall : sclk_rise; // see [R4] see [R5]
  wire s_launch = pol ? sclk_rise : sclk_fall; // see [R3] see [R5]
  wire cap_ev = is_master ? m_cap : s_cap;
  wire launch_ev = is_master ? m_cap : s_launch;

  //////////////////////////////////////////////////////////////////////////////
  // Conversion control

  conv_state_type state;
  conv_state_type next_state;
  logic [4:0] mcnt;
  logic [4:0] next_mcnt;
  logic [CAL_W-1:0] cal_cnt;
  logic sw_run;
  logic fifo_in_ready;
  logic active;
  logic rd_phase;
  logic [4:0] cnt;

  // A full buffer refuses new conversions, but a host-framed slave frame drops its word
  wire can_start = (state == ST_IDLE) && !calibrating && fifo_in_ready;
  wire sw_go = sw_convert_start && !locked_out; // see [R18]
  wire start_req = (convert_start_n_fall || sw_go) && can_start; // see [R10] see [R17]
  wire lead_done = (state == ST_LEAD) && mclk_rise
                   && (mcnt == `SYNC_LEAD_LAST); // see [R11] see [R14]
  wire conv_done = (state == ST_CONV) && mclk_rise && (mcnt == `CONV_LAST);
  wire frame_last = active && cap_ev && !rd_phase && (cnt == `LAST_BIT);
  wire master_end = (state == ST_FRAME) && frame_last; // see [R12] see [R16]

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_req && !is_master) begin
          next_state = ST_CONV;
        end else if (start_req && sw_go && !convert_start_n_fall) begin
          next_state = ST_LEAD;
        end else if (start_req) begin
          next_state = ST_ARM;
        end
      end
      ST_ARM: begin
        if (convert_start_n_rise) begin
          next_state = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (lead_done) begin
          next_state = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (master_end) begin
          next_state = ST_IDLE;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  assign next_mcnt = (next_state != state) ? `CNT_RST
                     : mclk_rise ? mcnt + 5'h01 : mcnt;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      mcnt <= `CNT_RST;
    end else begin
      state <= next_state;
      mcnt <= next_mcnt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      sw_run <= 1'b0;
    end else begin
      busy <= start_req || (busy && !master_end && !conv_done); // see [R10]
      sw_run <= start_req ? !convert_start_n_fall : sw_run;
    end
  end

  // Lockout set wins over a clear arriving in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      locked_out <= 1'b0;
    end else begin
      locked_out <= (master_end && sw_run)
                    || (locked_out && !convert_start_n_fall && !convert_start_n_rise); // see [R18]
    end
  end

  // Calibration needs the master clock running after reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      calibrating <= 1'b1;
      cal_cnt <= '0;
    end else if (calibrating && mclk_rise) begin
      cal_cnt <= cal_cnt + 1'b1;
      calibrating <= (cal_cnt != CAL_W'(CAL_MCLKS - 1)); // see [R19]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock and frame sync outputs

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_out <= 1'b0;
      sclk_oe <= 1'b0;
      sync_out <= 1'b1;
      sync_oe <= 1'b0;
    end else begin
      sclk_out <= is_master && !calibrating && pin_s2.mclk
                  && (mode == MODE_FREE || !sync_out); // see [R7] see [R8]
      sclk_oe <= is_master; // see [R7]
      sync_out <= !lead_done && (sync_out || master_end || !is_master);
      sync_oe <= is_master;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shift engine

  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  logic [15:0] next_tx;
  logic [15:0] next_rx;
  logic [4:0] next_cnt;
  logic next_active;
  logic next_rd;

  wire frame_start = is_master ? lead_done : sync_fall; // see [R1] see [R24]
  wire frame_abort = (!is_master && pin_s2.sync) || master_end; // see [R6]
  wire shift_ev = launch_ev && (is_master ? (cnt < `LAST_BIT)
                  : (cnt != `CNT_RST && cnt < `WORD_BITS));
  wire [15:0] word_in = {rx_sh[14:0], pin_s2.din};
  wire push_ok = frame_last && !two_wire && word_in != `WORD_RST
                 && !locked_out; // see [R21] see [R18]
  wire push_2w = frame_last && two_wire && word_in != `WORD_RST;

  always_comb begin
    next_active = active;
    next_cnt = cnt;
    next_rd = rd_phase;
    next_tx = tx_sh;
    next_rx = rx_sh;
    if (frame_start) begin
      next_active = 1'b1;
      next_cnt = `CNT_RST;
      next_rd = 1'b0;
      next_tx = result_word; // see [R9]
    end else if (frame_abort) begin
      next_active = 1'b0;
    end else if (active) begin
      if (shift_ev) begin
        next_tx = {tx_sh[14:0], 1'b0};
      end
      if (cap_ev && cnt != `WORD_BITS) begin
        next_rx = word_in;
        next_cnt = cnt + 5'h01; // see [R25]
      end
      if (frame_last && two_wire) begin
        next_rd = 1'b1;
        next_cnt = `CNT_RST;
        next_tx = result_word;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      active <= 1'b0;
      cnt <= `CNT_RST;
      rd_phase <= 1'b0;
      tx_sh <= `WORD_RST;
      rx_sh <= `WORD_RST;
    end else begin
      active <= next_active;
      cnt <= next_cnt;
      rd_phase <= next_rd;
      tx_sh <= next_tx;
      rx_sh <= next_rx;
    end
  end

  // Two-wire mode turns the input line around for the read half
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dout <= 1'b0;
      dout_oe <= 1'b0;
      din_out <= 1'b0;
      din_oe <= 1'b0;
    end else begin
      dout <= next_tx[15];
      dout_oe <= next_active && !two_wire; // see [R3]
      din_out <= next_tx[15];
      din_oe <= next_active && next_rd && next_cnt != `WORD_BITS; // see [R20]
    end
  end

  word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) write_buf (
    .clk(sys_clk),
    .resetn(resetn),
    .in_valid(push_ok || push_2w),
    .in_data(word_in),
    .in_ready(fifo_in_ready),
    .out_valid(wr_valid),
    .out_data(wr_data),
    .out_ready(wr_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  frame_begin_a: assert property (!is_master && sync_fall |=> active && cnt == 5'h00) else $error("frame did not start at sync fall"); // see [R1]
  count_cap_a: assert property (cnt <= 5'h10) else $error("bit counter above 16"); // see [R25]
  float_high_a: assert property (!is_master && pin_s2.sync |=> !dout_oe) else $error("output driven while sync high"); // see [R3]
  busy_start_a: assert property (convert_start_n_fall && can_start |=> busy) else $error("busy not raised"); // see [R10]
  sync_lead_a: assert property (state == ST_ARM && convert_start_n_rise |=> ##[1:1000] !sync_out) else $error("sync never fell"); // see [R11]
  sync_fall_a: assert property ($fell(sync_out) |-> $past(mclk_rise)) else $error("sync fell off a clock rise"); // see [R14]
  frame_end_a: assert property ($rose(sync_out) |-> $fell(busy)) else $error("sync and busy disagree at end"); // see [R12]
  zero_write_a: assert property (push_ok |-> word_in != 16'h0000) else $error("zero word stored"); // see [R21]
  lock_hold_a: assert property (locked_out && !convert_start_n_fall && !convert_start_n_rise |=> locked_out && !push_ok) else $error("lockout lost"); // see [R18]
  cal_stop_a: assert property (calibrating |=> !sclk_out) else $error("clock ran in calibration"); // see [R7]

  master_frame_c: cover property (master_end);
  slave_push_c: cover property (push_ok && !is_master);
  lockout_c: cover property ($rose(locked_out));
endmodule : adc_serial_port

`default_nettype wire

// ==== verification/host_port_model.sv ====
// Host serial port model: frames in slave modes, follows in master modes
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module host_port_model (
  // Bench control
  input wire logic go,
  input wire logic master,
  input wire logic pol,
  input wire logic [15:0] tx_word,
  output logic [15:0] rx_word,
  output logic done,
  // Serial link
  input wire logic sclk_out,
  input wire logic sync_out,
  input wire logic dout,
  output logic sclk_in,
  output logic sync_in,
  output logic din_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ph;
  // Clock stands still between frames
  assign sclk_in = ph ^ pol;
  initial begin
    ph = 1'b0;
    sync_in = 1'b1;
    din_in = 1'b0;
    rx_word = 16'h0000;
    done = 1'b0;
    forever begin
      @(posedge go);
      done = 1'b0;
      din_in = tx_word[15];
      if (master) begin
        @(negedge sync_out);
        for (int i = 15; i >= 0; i--) begin
          // Change data mid-bit, far from the capture rise
          @(negedge sclk_out);
          rx_word[i] = dout;
          din_in = tx_word[i];
        end
        @(posedge sync_out);
      end else begin
        sync_in = 1'b1;
        #125 sync_in = 1'b0;
        #62.5;
        for (int i = 15; i >= 0; i--) begin
          din_in = tx_word[i];
          #62.5 ph = 1'b1;
          rx_word[i] = dout;
          #62.5 ph = 1'b0;
        end
      end
      // Released line shows the inverse, not a stale bit
      din_in = ~tx_word[0];
      done = 1'b1;
    end
  end
endmodule : host_port_model

`default_nettype wire

// ==== verification/tb_adc_serial_port.sv ====
// Self-checking bench of the converter serial port
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module tb_adc_serial_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, resetn, mclk, convert_start_n_n, pol, sw_start, wr_ready, go;
  logic [1:0] msel;
  logic [15:0] result_word, tx, rx, wr_data;
  logic done, sclk_in, sclk_out, sclk_oe, sync_in, sync_out, sync_oe;
  logic din_in, dout, dout_oe, busy, calibrating, locked_out, wr_valid;
  logic [15:0] got[$];
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  adc_serial_port #(.CAL_MCLKS(8)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .master_clock_input(mclk),
    .convert_start_n(convert_start_n_n), .mode_select_hi(msel[1]),
    .mode_select_lo(msel[0]), .polarity(pol),
    .sw_convert_start(sw_start), .two_wire_select(1'b0),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
    .din_in(din_in), .din_out(), .din_oe(), .dout(dout),
    .dout_oe(dout_oe), .result_word(result_word), .busy(busy),
    .calibrating(calibrating), .locked_out(locked_out),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready)
  );

  host_port_model host (
    .go(go), .master(msel[1]), .pol(pol), .tx_word(tx), .rx_word(rx),
    .done(done), .sclk_out(sclk_out), .sync_out(sync_out), .dout(dout),
    .sclk_in(sclk_in), .sync_in(sync_in), .din_in(din_in)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    mclk = 1'b0;
    forever #62.5 mclk = ~mclk;
  end

  always @(posedge sys_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back(wr_data);
  end

  ////////////////////////////////////////////////////////////////////////////

  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 100000) begin
      failures++;
      $display("unexpected run length: expected end, seen limit");
      close_out();
    end
  end

  task automatic check16(input string what, input logic [15:0] exp,
                         input logic [15:0] seen);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check16

  task automatic check1(input string what, input logic exp, input logic seen);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %b, seen %b", what, exp, seen);
    end
  endtask : check1

  // how: 0 host framed, 1 pin start, 2 software start
  task automatic run(input logic [15:0] w, input int how);
    int n;
    tx = w;
    @(negedge sys_clk);
    go = 1'b1;
    convert_start_n_n = (how != 1);
    sw_start = (how == 2);
    @(negedge sys_clk);
    go = 1'b0;
    sw_start = 1'b0;
    repeat (7) @(negedge sys_clk);
    if (how == 0) check1("dout_oe", 1'b0, dout_oe);
    else check1("busy", 1'b1, busy);
    convert_start_n_n = 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (6) @(negedge sys_clk);
    check16("result", result_word, rx);
    // Acquisition gap before any further start
    repeat (34) @(negedge sys_clk);
  endtask : run

  // Counts bit clock changes over 40 cycles while idle
  task automatic toggles(output int t);
    logic last;
    t = 0;
    last = sclk_out;
    repeat (40) begin
      @(negedge sys_clk);
      if (sclk_out !== last) t++;
      last = sclk_out;
    end
  endtask : toggles

  ////////////////////////////////////////////////////////////////////////////

  initial begin
    int n;
    int t;
    resetn = 1'b0;
    convert_start_n_n = 1'b1;
    pol = 1'b0;
    sw_start = 1'b0;
    wr_ready = 1'b0;
    go = 1'b0;
    msel = 2'b01;
    tx = 16'h0000;
    result_word = 16'h0000;
    repeat (5) @(negedge sys_clk);
    check1("sync_out", 1'b1, sync_out);
    check1("calibrating", 1'b1, calibrating);
    resetn = 1'b1;
    n = 0;
    while (calibrating !== 1'b0 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    check1("calibrating", 1'b0, calibrating);
    check1("sclk_oe", 1'b0, sclk_oe);
    $display("test reset and calibration done");

    // Edge slave: zero word, then fill the buffer past full
    result_word = 16'hc3a5;
    run(16'h0000, 0);
    check1("wr_valid", 1'b0, wr_valid);
    for (int i = 1; i <= 17; i++) begin
      pol = i[0];
      result_word = 16'h0101 * i[15:0];
      run(i[15:0], 0);
    end
    check1("wr_valid", 1'b1, wr_valid);
    check16("wr_data", 16'h0001, wr_data);
    wr_ready = 1'b1;
    repeat (40) @(negedge sys_clk);
    check16("stored words", 16'h0010, 16'(got.size()));
    foreach (got[k]) check16("stored word", 16'(k + 1), got[k]);
    got.delete();
    pol = 1'b0;
    $display("test edge slave framing and buffer done");

    // Gated then free master modes
    for (int m = 2; m <= 3; m++) begin
      msel = m[1:0];
      repeat (10) @(negedge sys_clk);
      toggles(t);
      check1("sclk_out running", m[0], t > 0);
      result_word = 16'h9c60 + m[15:0];
      run(16'h1234 + m[15:0], 1);
      check1("sclk_oe", 1'b1, sclk_oe);
      check1("sync_oe", 1'b1, sync_oe);
      check1("sync_out", 1'b1, sync_out);
      check1("busy", 1'b0, busy);
      check16("written", 16'h1234 + m[15:0], got[$]);
    end
    $display("test master modes done");

    // Software start, lockout, release by the start pin
    result_word = 16'h2b4d;
    run(16'h0f0f, 2);
    check16("written", 16'h0f0f, got[$]);
    check1("locked_out", 1'b1, locked_out);
    @(negedge sys_clk) sw_start = 1'b1;
    @(negedge sys_clk) sw_start = 1'b0;
    repeat (20) @(negedge sys_clk);
    check1("busy", 1'b0, busy);
    run(16'h5555, 1);
    check1("locked_out", 1'b0, locked_out);
    check16("written", 16'h5555, got[$]);
    $display("test software start done");
    close_out();
  end
endmodule : tb_adc_serial_port

`default_nettype wire
